// File: hdl/seg_disp_pkg.sv
// Package: constants and carrier types for the seven-segment word display
package seg_disp_pkg;
  localparam int WORD_W = 16;
  localparam int CHAR_W = 8;
  localparam int SEG_W = 7;
  localparam int DIGITS = 4;
  localparam int HI_LSB = 8;
  localparam int LO_LSB = 0;
  localparam int DP_BIT = 7;
  localparam logic [SEG_W-1:0] SEG_RST = 7'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [6:0] HEX_CODE [16] = '{
    7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h27,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71
  };

  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic dp;
  } digit_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } word_in_t;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10
  } wstate_t;
endpackage

// File: hdl/seven_segment_word_display.sv
// Seven-segment word display: two words into four digits
//
// Behaviour
// - Each 16-bit word is split into two independent 8-bit character codes.
// - Upper byte drives left digit of a pair, lower byte the right digit.
// - Bit one lights a segment; bits 0 to 6 map to segments A to G.
// - Decimal point shows display mode only; data bit 7 is ignored.
// - Upper and lower bytes decode identically.
// - Hex digits 0 to F use the fixed segment code table.
`timescale 1ns/1ps
module seven_segment_word_display
  import seg_disp_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Display words from the link logic
  input wire word_in_t i_word,
  input wire logic i_restart,
  // Current display mode, shown on the decimal points
  input wire logic [1:0] i_mode,
  // Optional hex encoder: shows a raw 16-bit value as four hex digits
  input wire logic i_hex_valid,
  input wire logic [WORD_W-1:0] i_hex_value,
  // Segment outputs, digit 0 is leftmost
  output digit_t o_digit [DIGITS],
  output logic o_frame_done
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam int NIB_W = 4;
  localparam logic [1:0] MODE_NONE = 2'h0;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wstate_t state_r;
  logic [CHAR_W-1:0] first_hi_r;
  logic [CHAR_W-1:0] first_lo_r;
  logic done_r;
  logic word_take;
  logic first_take;
  logic pair_done;
  logic hex_load;
  logic char_load;
  logic any_load;
  logic [CHAR_W-1:0] pair_char [DIGITS];

  // ----------------------------------------
  // Word acceptance
  // ----------------------------------------
  // A restart wins over a word in the same cycle, so a new pair starts clean
  assign word_take = i_word.valid && !i_restart;

  // First word of a pair is held for later
  assign first_take = word_take && (state_r == ST_FIRST);

  // Second word of a pair completes the frame
  assign pair_done = word_take && (state_r == ST_SECOND);

  // ----------------------------------------
  // Pair state
  // ----------------------------------------
  // Restart drops a half-received pair
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_FIRST;
    end else if (i_restart) begin
      state_r <= ST_FIRST;
    end else if (i_word.valid) begin
      case (state_r)
        ST_FIRST: begin
          state_r <= ST_SECOND;
        end
        ST_SECOND: begin
          state_r <= ST_FIRST;
        end
        default: begin
          state_r <= ST_FIRST;
        end
      endcase
    end
  end

  // ----------------------------------------
  // First word hold
  // ----------------------------------------
  // Only the first word is stored; the second is used in the cycle it arrives
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_hi_r <= '0;
    end else if (first_take) begin
      first_hi_r <= i_word.data[HI_LSB +: CHAR_W];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_lo_r <= '0;
    end else if (first_take) begin
      first_lo_r <= i_word.data[LO_LSB +: CHAR_W];
    end
  end

  // ----------------------------------------
  // Byte routing
  // ----------------------------------------
  // First word feeds digits 0 and 1, second word digits 2 and 3
  always_comb begin
    pair_char[0] = first_hi_r;
    pair_char[1] = first_lo_r;
    pair_char[2] = i_word.data[HI_LSB +: CHAR_W];
    pair_char[3] = i_word.data[LO_LSB +: CHAR_W];
  end

  // ----------------------------------------
  // Load select
  // ----------------------------------------
  // Hex load wins over a pair; the pair state still advances beneath it
  assign hex_load = i_hex_valid;
  assign char_load = pair_done && !i_hex_valid;
  assign any_load = hex_load || char_load;

  // ----------------------------------------
  // Per-digit decode and latch
  // ----------------------------------------
  for (genvar d = 0; d < DIGITS; d++) begin : g_digit
    logic [NIB_W-1:0] hex_nib;
    logic [SEG_W-1:0] hex_seg;
    logic [SEG_W-1:0] char_seg;
    logic [SEG_W-1:0] seg_nxt;
    logic [SEG_W-1:0] seg_r;
    logic dot_nxt;
    logic dp_r;

    // Nibble 15:12 lands on the leftmost digit
    assign hex_nib = i_hex_value[(DIGITS-1-d)*NIB_W +: NIB_W];

    // Hex digits 0 to F through the fixed code table
    always_comb begin
      hex_seg = SEG_RST;
      case (hex_nib)
        4'h0: hex_seg = HEX_CODE[0];
        4'h1: hex_seg = HEX_CODE[1];
        4'h2: hex_seg = HEX_CODE[2];
        4'h3: hex_seg = HEX_CODE[3];
        4'h4: hex_seg = HEX_CODE[4];
        4'h5: hex_seg = HEX_CODE[5];
        4'h6: hex_seg = HEX_CODE[6];
        4'h7: hex_seg = HEX_CODE[7];
        4'h8: hex_seg = HEX_CODE[8];
        4'h9: hex_seg = HEX_CODE[9];
        4'ha: hex_seg = HEX_CODE[10];
        4'hb: hex_seg = HEX_CODE[11];
        4'hc: hex_seg = HEX_CODE[12];
        4'hd: hex_seg = HEX_CODE[13];
        4'he: hex_seg = HEX_CODE[14];
        4'hf: hex_seg = HEX_CODE[15];
        default: hex_seg = SEG_RST;
      endcase
    end

    // Top bit dropped here, so a stray bit 7 never reaches the dot
    assign char_seg = pair_char[d][SEG_W-1:0];

    always_comb begin
      seg_nxt = seg_r;
      if (hex_load) begin
        seg_nxt = hex_seg;
      end else if (char_load) begin
        seg_nxt = char_seg;
      end
    end

    // Held between loads, so a half-received pair never shows
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        seg_r <= SEG_RST;
      end else begin
        seg_r <= seg_nxt;
      end
    end

    // Digit 0 has no mode of its own: mode 0 leaves all dots dark
    always_comb begin
      dot_nxt = 1'b0;
      case (i_mode)
        MODE_NONE: dot_nxt = 1'b0;
        default: dot_nxt = (i_mode == 2'(d));
      endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        dp_r <= 1'b0;
      end else begin
        dp_r <= dot_nxt;
      end
    end

    assign o_digit[d] = '{seg: seg_r, dp: dp_r};
  end

  // ----------------------------------------
  // Completion pulse
  // ----------------------------------------
  // One cycle high for every load that refreshes all four digits
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= any_load;
    end
  end

  assign o_frame_done = done_r;

endmodule

// File: test/seg_props.sv
// Checker on the display ports
`timescale 1ns/1ps
module seg_props
  import seg_disp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire word_in_t i_word,
  input wire logic i_restart,
  input wire logic [1:0] i_mode,
  input wire logic i_hex_valid,
  input wire logic [WORD_W-1:0] i_hex_value,
  input wire digit_t o_digit [DIGITS],
  input wire logic o_frame_done
);
  logic h_r;
  logic [15:0] f_r;
  wire logic tk = i_word.valid && !i_restart;
  wire logic sc = tk && h_r && !i_hex_valid;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) h_r <= 1'h0;
    else h_r <= i_restart ? 1'h0 : h_r ^ i_word.valid;
  end
  always_ff @(posedge i_mclk) if (tk && !h_r) f_r <= i_word.data;
  pair_done_a: assert property (sc |=> o_frame_done) else $error("no done");
  odd_word_a: assert property (tk && !h_r && !i_hex_valid |=> !o_frame_done)
    else $error("early done");
  right_byte_a: assert property (sc |=> o_digit[3].seg == $past(i_word.data[6:0]))
    else $error("bad right");
  left_byte_a: assert property (sc |=> o_digit[2].seg == $past(i_word.data[14:8]))
    else $error("bad left");
  first_word_a: assert property (sc |=> {o_digit[0].seg, o_digit[1].seg} ==
    {f_r[14:8], f_r[6:0]}) else $error("bad first");
  hex_code_a: assert property (i_hex_valid |=>
    o_digit[0].seg == HEX_CODE[$past(i_hex_value[15:12])]) else $error("bad hex");
  mode_dot_a: assert property (1'h1 |=> o_digit[2].dp == ($past(i_mode) == 2'h2))
    else $error("bad dot");
endmodule
bind seven_segment_word_display seg_props u_p (.*);

// File: test/seg_src.sv
// Controller model writing display words
`timescale 1ns/1ps
module seg_src
  import seg_disp_pkg::*;
(
  input wire logic i_mclk,
  output word_in_t o_word
);
  initial o_word = '0;
  // Idle data is inverted so a word read after its valid cycle shows wrong segments
  task put(input logic v, input logic [15:0] d);
    @(negedge i_mclk) o_word <= '{v, v ? d & 16'h7f7f : ~d};
  endtask
endmodule

// File: test/tb_seven_segment_word_display.sv
// Bench for the seven-segment word display
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb_seven_segment_word_display;
  import seg_disp_pkg::*;
  logic i_mclk = 1'h0, i_arst_n = 1'h0, i_restart = 1'h0, i_hex_valid = 1'h0;
  logic [1:0] i_mode = 2'h0;
  logic [15:0] i_hex_value = 16'h0;
  word_in_t i_word;
  digit_t o_digit [DIGITS];
  logic o_frame_done;
  int errors = 0, total_checks = 0;
  // Rows: two words in, then the four expected segment bytes, leftmost first
  logic [63:0] rows [3] = '{64'h7950_5006_7950_5006, 64'h3f06_5b4f_3f06_5b4f,
    64'h0006_6d7d_0006_6d7d};
  logic [7:0] hex_exp [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  always #5 i_mclk = ~i_mclk;
  seg_src u_src (.i_mclk(i_mclk), .o_word(i_word));
  seven_segment_word_display uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_word(i_word),
    .i_restart(i_restart), .i_mode(i_mode), .i_hex_valid(i_hex_valid),
    .i_hex_value(i_hex_value), .o_digit(o_digit), .o_frame_done(o_frame_done));
  task test_done;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task pair(input logic [63:0] r);
    u_src.put(1'h1, r[63:48]);
    u_src.put(1'h1, r[47:32]);
    `CK(o_frame_done, 1'h0)
    u_src.put(1'h0, r[47:32]);
    `CK(o_frame_done, 1'h1)
    for (int i = 0; i < 4; i++) `CK(o_digit[i].seg, r[31-8*i -: 8])
  endtask
  initial begin
    repeat (4) @(negedge i_mclk);
    for (int i = 0; i < 4; i++) `CK(o_digit[i], 8'h00)
    `CK(o_frame_done, 1'h0)
    i_arst_n = 1'h1;
    foreach (rows[r]) pair(rows[r]);
    // Restart drops the pending first word and the word given with it
    u_src.put(1'h1, 16'h0606);
    u_src.put(1'h1, 16'h0606);
    i_restart = 1'h1;
    u_src.put(1'h0, 16'h0606);
    i_restart = 1'h0;
    `CK(o_frame_done, 1'h0)
    pair(64'h7727_5e39_7727_5e39);
    // Hex load in the cycle that completes a pair wins; pairing still advances
    u_src.put(1'h1, 16'h0606);
    u_src.put(1'h1, 16'h0606);
    i_hex_valid = 1'h1;
    i_hex_value = 16'h0123;
    u_src.put(1'h0, 16'h0606);
    i_hex_valid = 1'h0;
    for (int d = 0; d < 4; d++) `CK(o_digit[d].seg, hex_exp[d])
    pair(64'h5b5b_4f4f_5b5b_4f4f);
    // Reset in mid-pair clears the digits and the pending word
    u_src.put(1'h1, 16'h3f3f);
    u_src.put(1'h0, 16'h3f3f);
    i_arst_n = 1'h0;
    @(negedge i_mclk);
    for (int i = 0; i < 4; i++) `CK(o_digit[i], 8'h00)
    i_arst_n = 1'h1;
    pair(64'h0606_3f3f_0606_3f3f);
    for (int n = 0; n < 16; n++) begin
      @(negedge i_mclk) i_hex_valid = 1'h1;
      i_hex_value = {4'(n), 4'(n + 1), 4'(n + 2), 4'(n + 3)};
      i_mode = 2'(n);
      @(negedge i_mclk) i_hex_valid = 1'h0;
      `CK(o_frame_done, 1'h1)
      for (int d = 0; d < 4; d++) begin
        `CK(o_digit[d].seg, hex_exp[(n + d) % 16])
        `CK(o_digit[d].dp, (n % 4 == d) && (n % 4 != 0))
      end
    end
    test_done;
  end
  initial begin
    #5000;
    errors++;
    test_done;
  end
endmodule
